/* File: rtl/tap_pkg.sv */
// ==========================================================
// test access port constants
package tap_pkg;

	// instruction register
	localparam int IR_LEN = 3;
	localparam logic [2:0] INSN_EXTEST = 3'h0;
	localparam logic [2:0] INSN_IDCODE = 3'h1;
	localparam logic [2:0] INSN_SAMPLE = 3'h2;
	localparam logic [2:0] INSN_CLAMP = 3'h3;
	localparam logic [2:0] INSN_HIGHZ = 3'h4;
	localparam logic [2:0] INSN_BYPASS = 3'h7;
	// fixed pattern loaded in capture-ir, two low bits 01
	localparam logic [2:0] IR_CAPTURE_VAL = 3'h1;
	localparam logic [2:0] IR_RESET_VAL = INSN_IDCODE;

	// identification register layout
	localparam int ID_LEN = 32;
	localparam int ID_MFR_POS = 1;
	localparam int ID_MFR_LEN = 11;
	localparam int ID_PART_POS = 12;
	localparam int ID_PART_LEN = 16;
	localparam int ID_VER_POS = 28;
	localparam int ID_VER_LEN = 4;
	localparam logic ID_MARKER_BIT = 1'h1;

	// boundary register default length (cells 0 to 72)
	localparam int BSR_LEN_DEFAULT = 73;

	// link clock period seen by the sampler, for reference only
	localparam int TCK_PERIOD_NS = 160;
	localparam int MCLK_PERIOD_NS = 20;
	localparam int TCK_MCLK_RATIO = TCK_PERIOD_NS / MCLK_PERIOD_NS;

	typedef enum logic [15:0] {
		ST_RESET = 16'h0001,
		ST_IDLE = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SHIFT_DR = 16'h0010,
		ST_EXIT1_DR = 16'h0020,
		ST_PAUSE_DR = 16'h0040,
		ST_EXIT2_DR = 16'h0080,
		ST_UPD_DR = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SHIFT_IR = 16'h0800,
		ST_EXIT1_IR = 16'h1000,
		ST_PAUSE_IR = 16'h2000,
		ST_EXIT2_IR = 16'h4000,
		ST_UPD_IR = 16'h8000
	} tap_state_t;

endpackage

/* File: rtl/boundary_scan_tap.sv */
// Contract
// - state moves on rising test clock only; test reset pin low forces reset state
// - power-up: reset state, identify instruction current
// - select-dr: low to capture, high select-ir
// - capture-dr loads selected register, then shift/exit1
// - shift-dr shifts selected register one stage
// - exit1-dr update/pause; pause holds while low
// - exit2-dr: high update, low back shift
// - update-dr copies shift stage on falling edge
// - select-ir: low capture-ir, high to reset
// - capture-ir loads fixed pattern, then exit1/shift
// - shift-ir shifts instruction stage, high exits
// - exit1-ir pause/update; pause-ir holds while low
// - exit2-ir: high update, low back shift
// - update-ir latches instruction on falling edge
// - instruction register three bits, shift plus latch
// - code 111 routes through one-bit bypass
// - code 010 samples pins into boundary register
// - code 000 drives outputs from boundary latches
// - code 011 bypass, outputs frozen from boundary
// - code 100 floats outputs, bypass in path
// - code 001 captures and shifts identity value
// - identity: bit0 one, maker, part, version
// - identity 32-bit, selected also in reset state
`timescale 1ns/1ps
`default_nettype none

module boundary_scan_tap
	import tap_pkg::*;
#(
	parameter int BSR_LEN = BSR_LEN_DEFAULT,
	// arbitrary neutral identity values
	parameter logic [ID_MFR_LEN-1:0] MFR_CODE = 11'h055,
	parameter logic [ID_PART_LEN-1:0] PART_CODE = 16'h00a5,
	parameter logic [ID_VER_LEN-1:0] VER_CODE = 4'h1
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// test port pins
	input wire logic i_test_port_reset_n,
	input wire logic i_test_port_clock,
	input wire logic i_test_port_mode_select,
	input wire logic i_test_port_serial_in,
	output logic o_test_port_serial_out,
	output logic o_test_port_serial_out_oe,
	// boundary cells towards the pins
	input wire logic [BSR_LEN-1:0] i_bsr_capture,
	output logic [BSR_LEN-1:0] o_bsr_update,
	output logic o_pins_from_bsr,
	output logic o_pins_hiz
);

	// ==========================================================
	// parameter checks
	if (BSR_LEN < 2) begin : g_bad_len
		$error("boundary register must hold at least two cells");
	end

	// ==========================================================
	// helpers
	function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
		tap_state_t n;
		n = s;
		unique case (s)
			ST_RESET: n = tms ? ST_RESET : ST_IDLE;
			ST_IDLE: n = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: n = tms ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: n = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: n = tms ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR: n = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: n = tms ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: n = tms ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: n = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: n = tms ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR: n = tms ? ST_SEL_DR : ST_IDLE;
			default: n = ST_RESET;
		endcase
		return n;
	endfunction

	// boundary register sits in the path for extest and sample only
	function automatic logic sel_bsr(input logic [IR_LEN-1:0] ir);
		return (ir == INSN_EXTEST) || (ir == INSN_SAMPLE);
	endfunction

	function automatic logic sel_id(input logic [IR_LEN-1:0] ir, input tap_state_t s);
		return (ir == INSN_IDCODE) || (s == ST_RESET);
	endfunction

	localparam logic [ID_LEN-1:0] ID_VALUE = {VER_CODE, PART_CODE, MFR_CODE, ID_MARKER_BIT};

	// ==========================================================
	// pin synchronisers and edge finding
	logic [1:0] tck_sync_ff;
	logic [1:0] tms_sync_ff;
	logic [1:0] tdi_sync_ff;
	logic [1:0] trst_sync_ff;
	logic tck_prev_ff;
	logic tck_rise;
	logic tck_fall;
	logic tms_s;
	logic tdi_s;
	logic trst_act;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			tck_sync_ff <= 2'h0;
			tms_sync_ff <= 2'h3;
			tdi_sync_ff <= 2'h0;
			trst_sync_ff <= 2'h0;
			tck_prev_ff <= 1'h0;
		end else begin
			tck_sync_ff <= {tck_sync_ff[0], i_test_port_clock};
			tms_sync_ff <= {tms_sync_ff[0], i_test_port_mode_select};
			tdi_sync_ff <= {tdi_sync_ff[0], i_test_port_serial_in};
			trst_sync_ff <= {trst_sync_ff[0], i_test_port_reset_n};
			tck_prev_ff <= tck_sync_ff[1];
		end
	end

	// mode select and data cross with the same two-stage delay as the clock, so they line up with its edges
	assign tms_s = tms_sync_ff[1];
	assign tdi_s = tdi_sync_ff[1];
	assign trst_act = ~trst_sync_ff[1];
	assign tck_rise = tck_sync_ff[1] & ~tck_prev_ff;
	assign tck_fall = ~tck_sync_ff[1] & tck_prev_ff;

	// ==========================================================
	// controller state
	tap_state_t state_ff;
	tap_state_t nxt_state;

	always_comb begin
		nxt_state = state_ff;
		if (trst_act) begin
			nxt_state = ST_RESET;
		end else if (tck_rise) begin
			nxt_state = tap_next(state_ff, tms_s);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_ff <= ST_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ==========================================================
	// instruction and data registers
	logic [IR_LEN-1:0] ir_shift_ff;
	logic [IR_LEN-1:0] ir_ff;
	logic bypass_ff;
	logic [ID_LEN-1:0] id_shift_ff;
	logic [ID_LEN-1:0] id_latch_ff;
	logic [BSR_LEN-1:0] bsr_shift_ff;
	logic [BSR_LEN-1:0] bsr_latch_ff;
	logic [IR_LEN-1:0] nxt_ir_shift;
	logic [IR_LEN-1:0] nxt_ir;
	logic nxt_bypass;
	logic [ID_LEN-1:0] nxt_id_shift;
	logic [ID_LEN-1:0] nxt_id_latch;
	logic [BSR_LEN-1:0] nxt_bsr_shift;
	logic [BSR_LEN-1:0] nxt_bsr_latch;
	logic use_bsr;
	logic use_id;

	assign use_bsr = sel_bsr(ir_ff);
	assign use_id = sel_id(ir_ff, state_ff);

	always_comb begin
		nxt_ir_shift = ir_shift_ff;
		nxt_ir = ir_ff;
		nxt_bypass = bypass_ff;
		nxt_id_shift = id_shift_ff;
		nxt_id_latch = id_latch_ff;
		nxt_bsr_shift = bsr_shift_ff;
		nxt_bsr_latch = bsr_latch_ff;
		if (state_ff == ST_RESET) begin
			nxt_ir = IR_RESET_VAL;
		end
		if (tck_rise && !trst_act) begin
			unique case (state_ff)
				ST_CAP_IR: nxt_ir_shift = IR_CAPTURE_VAL;
				ST_SHIFT_IR: nxt_ir_shift = {tdi_s, ir_shift_ff[IR_LEN-1:1]};
				ST_CAP_DR: begin
					if (use_bsr) begin
						nxt_bsr_shift = i_bsr_capture;
					end else if (use_id) begin
						nxt_id_shift = ID_VALUE;
					end else begin
						nxt_bypass = 1'h0;
					end
				end
				ST_SHIFT_DR: begin
					if (use_bsr) begin
						nxt_bsr_shift = {tdi_s, bsr_shift_ff[BSR_LEN-1:1]};
					end else if (use_id) begin
						nxt_id_shift = {tdi_s, id_shift_ff[ID_LEN-1:1]};
					end else begin
						nxt_bypass = tdi_s;
					end
				end
				default: begin
				end
			endcase
		end
		if (tck_fall && !trst_act) begin
			if (state_ff == ST_UPD_IR) begin
				nxt_ir = ir_shift_ff;
			end
			// clamp leaves the latches alone since the boundary register is not selected
			if (state_ff == ST_UPD_DR) begin
				if (use_bsr) begin
					nxt_bsr_latch = bsr_shift_ff;
				end else if (use_id) begin
					nxt_id_latch = id_shift_ff;
				end
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ir_shift_ff <= IR_CAPTURE_VAL;
			ir_ff <= IR_RESET_VAL;
			bypass_ff <= 1'h0;
			id_shift_ff <= '0;
			id_latch_ff <= '0;
			bsr_shift_ff <= '0;
			bsr_latch_ff <= '0;
		end else begin
			ir_shift_ff <= nxt_ir_shift;
			ir_ff <= nxt_ir;
			bypass_ff <= nxt_bypass;
			id_shift_ff <= nxt_id_shift;
			id_latch_ff <= nxt_id_latch;
			bsr_shift_ff <= nxt_bsr_shift;
			bsr_latch_ff <= nxt_bsr_latch;
		end
	end

	// ==========================================================
	// pin side outputs and serial out
	logic nxt_tdo;
	logic nxt_tdo_oe;
	logic nxt_from_bsr;
	logic nxt_hiz;

	always_comb begin
		nxt_tdo = o_test_port_serial_out;
		nxt_tdo_oe = o_test_port_serial_out_oe;
		// extest and clamp drive pins from the latches; clamp keeps them still
		nxt_from_bsr = (ir_ff == INSN_EXTEST) || (ir_ff == INSN_CLAMP);
		nxt_hiz = (ir_ff == INSN_HIGHZ);
		// serial out changes on the falling edge so the tester samples a settled bit
		if (trst_act) begin
			nxt_tdo_oe = 1'h0;
		end else if (tck_fall) begin
			nxt_tdo_oe = (state_ff == ST_SHIFT_DR) || (state_ff == ST_SHIFT_IR);
			if (state_ff == ST_SHIFT_IR) begin
				nxt_tdo = ir_shift_ff[0];
			end else if (use_bsr) begin
				nxt_tdo = bsr_shift_ff[0];
			end else if (use_id) begin
				nxt_tdo = id_shift_ff[0];
			end else begin
				nxt_tdo = bypass_ff;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_test_port_serial_out <= 1'h0;
			o_test_port_serial_out_oe <= 1'h0;
			o_pins_from_bsr <= 1'h0;
			o_pins_hiz <= 1'h0;
			o_bsr_update <= '0;
		end else begin
			o_test_port_serial_out <= nxt_tdo;
			o_test_port_serial_out_oe <= nxt_tdo_oe;
			o_pins_from_bsr <= nxt_from_bsr;
			o_pins_hiz <= nxt_hiz;
			o_bsr_update <= bsr_latch_ff;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst || trst_act);

	sequence s_step_low;
		tck_rise && !tms_s;
	endsequence
	sequence s_step_high;
		tck_rise && tms_s;
	endsequence

	a_hold_no_edge: assert property (!tck_rise |=> state_ff == $past(state_ff))
		else $error("state moved without a rising test clock");
	a_sel_dr_path: assert property (state_ff == ST_SEL_DR ##0 s_step_low |=> state_ff == ST_CAP_DR)
		else $error("select-dr did not reach capture-dr");
	a_sel_ir_path: assert property (state_ff == ST_SEL_IR ##0 s_step_high |=> state_ff == ST_RESET)
		else $error("select-ir did not return to reset");
	a_exit2_ir_dir: assert property (state_ff == ST_EXIT2_IR ##0 s_step_high |=> state_ff == ST_UPD_IR)
		else $error("exit2-ir high did not reach update-ir");
	a_exit2_dr_dir: assert property (state_ff == ST_EXIT2_DR ##0 s_step_low |=> state_ff == ST_SHIFT_DR)
		else $error("exit2-dr low did not return to shift-dr");
	a_pause_holds: assert property (state_ff == ST_PAUSE_DR ##0 s_step_low |=> state_ff == ST_PAUSE_DR
		&& bsr_shift_ff == $past(bsr_shift_ff))
		else $error("pause-dr moved or shifted");
	a_ir_capture: assert property (state_ff == ST_CAP_IR && tck_rise |=> ir_shift_ff == IR_CAPTURE_VAL)
		else $error("capture-ir did not load the fixed pattern");
	a_ir_latch: assert property (state_ff == ST_UPD_IR && tck_fall |=> ir_ff == $past(ir_shift_ff))
		else $error("update-ir did not latch the instruction");
	a_ir_steady: assert property (state_ff == ST_SHIFT_IR |=> ir_ff == $past(ir_ff))
		else $error("current instruction changed during shift-ir");
	a_id_capture: assert property (state_ff == ST_CAP_DR && tck_rise && ir_ff == INSN_IDCODE
		|=> id_shift_ff == ID_VALUE && id_shift_ff[0] == 1'h1)
		else $error("identity value not captured");
	a_reset_insn: assert property (state_ff == ST_RESET |=> ir_ff == INSN_IDCODE)
		else $error("reset state did not force identify instruction");
	a_clamp_frozen: assert property (ir_ff == INSN_CLAMP && $past(ir_ff) == INSN_CLAMP
		|-> bsr_latch_ff == $past(bsr_latch_ff))
		else $error("boundary latches moved under clamp");
	a_hiz_follows: assert property (ir_ff == INSN_HIGHZ ##1 ir_ff == INSN_HIGHZ |-> o_pins_hiz)
		else $error("high impedance flag missing");
	a_bypass_shift: assert property (state_ff == ST_SHIFT_DR && tck_rise && ir_ff == INSN_BYPASS
		|=> bypass_ff == $past(tdi_s))
		else $error("bypass bit did not take serial input");

endmodule

`default_nettype wire

/* File: dv/scan_tester_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// tester model: the link clock runs only inside frames and rests low
module scan_tester_model (
	// clock
	input wire logic i_mclk,
	// test port
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi,
	input wire logic i_tdo
);
	localparam int HALF = 4;
	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b0;
	end
	// one 160 ns period; tdo is read just before the fall, so it still
	// holds what the previous fall launched
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		@(posedge i_mclk);
		o_tms <= tms;
		o_tdi <= tdi;
		repeat (HALF - 1) @(posedge i_mclk);
		o_tck <= 1'b1;
		repeat (HALF) @(posedge i_mclk);
		tdo = i_tdo;
		o_tck <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: dv/boundary_scan_tap_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// top of the bench
module boundary_scan_tap_tb_top;
	import tap_pkg::*;
	localparam int BN = BSR_LEN_DEFAULT;
	// arbitrary identity values
	localparam logic [10:0] MFR = 11'h2a3;
	localparam logic [15:0] PART = 16'h5c17;
	localparam logic [3:0] VER = 4'h6;
	localparam logic [31:0] ID_EXP = {VER, PART, MFR, 1'b1};
	logic mclk, rst, trst_n, tck, tms, tdi, tdo, oe, from_bsr, hiz;
	logic [BN-1:0] cap, upd, held;
	logic [2:0] codes [5] = '{INSN_BYPASS, INSN_CLAMP, INSN_HIGHZ, 3'h5, 3'h6};
	int n_mismatch = 0;
	int total_checks = 0;

	boundary_scan_tap #(.BSR_LEN(BN), .MFR_CODE(MFR), .PART_CODE(PART), .VER_CODE(VER)) boundary_scan_tap_i (
		.i_mclk(mclk), .i_rst(rst), .i_test_port_reset_n(trst_n), .i_test_port_clock(tck),
		.i_test_port_mode_select(tms), .i_test_port_serial_in(tdi), .o_test_port_serial_out(tdo),
		.o_test_port_serial_out_oe(oe), .i_bsr_capture(cap), .o_bsr_update(upd),
		.o_pins_from_bsr(from_bsr), .o_pins_hiz(hiz));
	scan_tester_model scan_tester_model_i (.i_mclk(mclk), .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// ==========
	// checking and closing
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ==========
	// scans: start and end in run-test-idle; brk breaks the shift with a
	// pause and resumes through exit2 so both loop-back paths are used
	function automatic logic [127:0] rnd();
		return {$urandom, $urandom, $urandom, $urandom};
	endfunction
	task automatic st(input logic m);
		logic t;
		scan_tester_model_i.step(m, 1'b0, t);
	endtask
	task automatic scan(input bit ir, input int n, input logic [127:0] din, input bit brk, output logic [127:0] q);
		logic t;
		q = '0;
		st(1'b1);
		if (ir) st(1'b1);
		st(1'b0);
		st(1'b0);
		for (int i = 0; i < n; i++) begin
			scan_tester_model_i.step(i == n - 1 || (brk && i == n / 2 - 1), din[i], t);
			q[i] = t;
			if (i == 0) chk(oe, 1'b1, "oe in shift");
			if (brk && i == n / 2 - 1) begin
				st(1'b0);
				st(1'b0);
				st(1'b1);
				st(1'b0);
			end
		end
		if (brk) begin
			st(1'b0);
			st(1'b1);
		end
		st(1'b1);
		st(1'b0);
		chk(oe, 1'b0, "oe after scan");
	endtask
	task automatic load_ir(input logic [2:0] code);
		logic [127:0] q;
		scan(1'b1, IR_LEN, {125'h0, code}, 1'b1, q);
		chk(q[2:0], IR_CAPTURE_VAL, "ir capture");
	endtask
	task automatic read_id(input string name);
		logic [127:0] q;
		scan(1'b0, ID_LEN, rnd(), 1'b0, q);
		chk(q[31:0], ID_EXP, "identity");
		$display("test %s done", name);
	endtask

	// ==========
	// main sequence
	initial begin
		logic [127:0] d, q;
		rst = 1'b1;
		trst_n = 1'b1;
		cap = '0;
		void'($urandom(96373));
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
		chk({upd, from_bsr, hiz}, '0, "reset outputs");
		st(1'b0);
		read_id("power-up identity");
		cap <= BN'(rnd());
		load_ir(INSN_SAMPLE);
		chk({from_bsr, hiz}, 2'b00, "sample pin modes");
		d = rnd();
		scan(1'b0, BN, d, 1'b1, q);
		chk(q[BN-1:0], cap, "sample capture");
		chk(upd, d[BN-1:0], "preload latch");
		$display("test sample done");
		cap <= BN'(rnd());
		load_ir(INSN_EXTEST);
		chk({from_bsr, hiz}, 2'b10, "extest pin modes");
		d = rnd();
		scan(1'b0, BN, d, 1'b0, q);
		chk(q[BN-1:0], cap, "extest capture");
		chk(upd, d[BN-1:0], "extest latch");
		held = d[BN-1:0];
		$display("test extest done");
		foreach (codes[k]) begin
			load_ir(codes[k]);
			chk({from_bsr, hiz}, {codes[k] == INSN_CLAMP, codes[k] == INSN_HIGHZ}, "pin modes");
			d = rnd();
			scan(1'b0, 16, d, codes[k][0], q);
			chk(q[15:1], d[14:0], "bypass path");
			chk(upd, held, "latch frozen");
			$display("test code %h done", codes[k]);
		end
		st(1'b1);
		st(1'b1);
		st(1'b1);
		st(1'b0);
		chk({from_bsr, hiz}, 2'b00, "modes after reset state");
		read_id("select-ir to reset");
		load_ir(INSN_HIGHZ);
		@(posedge mclk);
		trst_n <= 1'b0;
		repeat (8) @(posedge mclk);
		trst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		chk({from_bsr, hiz}, 2'b00, "modes after test reset");
		st(1'b0);
		read_id("test reset pin");
		report_and_stop();
	end

	initial begin
		repeat (60000) @(posedge mclk);
		n_mismatch++;
		$display("Error at %0t: run did not finish", $time);
		report_and_stop();
	end
endmodule
`default_nettype wire
